// file: rtl/clk_enable_divider.sv
`timescale 1ns/1ps
module clk_enable_divider
  import clk_presc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [4:0] free_count,
  input wire logic [2:0] shift,
  output logic enable
);
  logic [4:0] mask;
  logic next_enable;
  assign mask = 5'((6'h01 << shift) - 6'h01);
  // Pulse once per 2^shift cycles; shift 0 gives every cycle
  assign next_enable = ((free_count & mask) == 5'h00);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      enable <= 1'b0;
    else
      enable <= next_enable;
  end
endmodule : clk_enable_divider

// file: rtl/clk_presc_defines.svh
`ifndef CLK_PRESC_DEFINES_SVH
`define CLK_PRESC_DEFINES_SVH
`define OFF_DIV_SEL 12'h03c
`define OFF_TRIM_CTRL 12'h040
`define DIV_SEL_RESET 32'h0000_0000
`define DIV_SEL_MASK 32'hff03_f03f
`define TRIM_WR_MASK 32'h00ff_0033
`define TRIM_LOW_RESET 16'h0000
`define FINE_DEFAULT 8'h80
`define F_TMR3 31:30
`define F_TMR2 29:28
`define F_TMR1 27:26
`define F_TMR0 25:24
`define F_SCI 17:16
`define F_BKP 15:14
`define F_WDT 13:12
`define F_ADC 5:4
`define F_EXTI 3:2
`define F_AFIO 1:0
`define F_COARSE 28:24
`define F_FINE 23:16
`define B_LOCK 7
`define B_REFSEL 5
`define B_MODE_SEL 4
`define B_AUTOTRIM_EN 1
`define B_TRIM_EN 0
`define BKP_BASE_SHIFT 3'h2
`define SYNC_SETTLE 2'h2
`define NUM_OUTS 10
`endif

// file: rtl/clk_presc_pkg.sv
package clk_presc_pkg;
  typedef struct packed {
    logic autotrim_ref_select;
    logic trim_mode_select;
    logic autotrim_enable;
    logic trim_function_enable;
    logic [7:0] fine_trim_value;
  } trim_ctrl_t;
  typedef enum logic [1:0] {
    div_by_1 = 2'b00,
    div_by_2 = 2'b01,
    div_by_4 = 2'b10,
    div_by_8 = 2'b11
  } div_code_t;
endpackage : clk_presc_pkg

// file: rtl/clk_presc_select.sv
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "clk_presc_defines.svh"
module clk_presc_select
  import clk_presc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [4:0] coarse_trim_value,
  input wire logic [7:0] factory_fine_trim,
  input wire logic freq_locked_flag,
  input wire logic [7:0] autotrim_fine_value,
  output logic timer3_clk_en,
  output logic timer2_clk_en,
  output logic timer1_clk_en,
  output logic timer0_clk_en,
  output logic smartcard_clk_en,
  output logic backup_access_clk_en,
  output logic watchdog_access_clk_en,
  output logic converter_clk_en,
  output logic ext_interrupt_clk_en,
  output logic altfunc_clk_en,
  output trim_ctrl_t trim_ctrl,
  output logic [7:0] fine_trim_to_osc
);
  logic [31:0] div_select;
  logic [4:0] coarse_sync1;
  logic [4:0] coarse_sync2;
  logic lock_sync1;
  logic lock_sync2;
  logic [7:0] atc_sync1;
  logic [7:0] atc_sync2;
  logic [7:0] fine_sync1;
  logic [7:0] fine_sync2;
  logic [7:0] atc_prev;
  logic [7:0] atc_value;
  logic loaded;
  logic [1:0] settle;
  logic [4:0] free_count;
  logic [2:0] shifts [`NUM_OUTS];

  // Register decode
  wire sel_div = (paddr == `OFF_DIV_SEL);
  wire sel_trim = (paddr == `OFF_TRIM_CTRL);
  wire hit = sel_div || sel_trim;
  wire setup = psel && !penable;
  wire access = psel && penable;
  wire wr_div = access && pwrite && sel_div;
  wire wr_trim = access && pwrite && sel_trim;
  wire rd_setup = setup && !pwrite;

  // Trim register image, reserved bits zero
  wire [31:0] trim_read = {3'h0,
                           coarse_sync2,
                           trim_ctrl.fine_trim_value,
                           8'h00,
                           lock_sync2,
                           1'b0,
                           trim_ctrl.autotrim_ref_select,
                           trim_ctrl.trim_mode_select,
                           2'b00,
                           trim_ctrl.autotrim_enable,
                           trim_ctrl.trim_function_enable};
  wire [31:0] next_prdata = sel_div ? div_select :
                            sel_trim ? trim_read : 32'h0000_0000;
  wire [31:0] next_div_select = pwdata & `DIV_SEL_MASK;
  wire [31:0] masked_wdata = pwdata & `TRIM_WR_MASK;

  // Autotrim word taken only when two samples agree
  wire atc_steady = (atc_sync2 == atc_prev);
  wire settled = (settle == `SYNC_SETTLE);
  wire auto_trim_active = trim_ctrl.autotrim_enable && !trim_ctrl.trim_mode_select;
  wire [7:0] next_fine = auto_trim_active ? atc_value : trim_ctrl.fine_trim_value;

  // Status pins come from the oscillator domain
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      coarse_sync1 <= 5'h00;
      coarse_sync2 <= 5'h00;
    end
    else
    begin
      coarse_sync1 <= coarse_trim_value;
      coarse_sync2 <= coarse_sync1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lock_sync1 <= 1'b0;
      lock_sync2 <= 1'b0;
    end
    else
    begin
      lock_sync1 <= freq_locked_flag;
      lock_sync2 <= lock_sync1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      atc_sync1 <= 8'h00;
      atc_sync2 <= 8'h00;
    end
    else
    begin
      atc_sync1 <= autotrim_fine_value;
      atc_sync2 <= atc_sync1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fine_sync1 <= 8'h00;
      fine_sync2 <= 8'h00;
    end
    else
    begin
      fine_sync1 <= factory_fine_trim;
      fine_sync2 <= fine_sync1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      atc_prev <= 8'h00;
      atc_value <= 8'h00;
    end
    else
    begin
      atc_prev <= atc_sync2;
      if (atc_steady)
        atc_value <= atc_sync2;
    end
  end

  // Counts edges until synchronisers hold pin values
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      settle <= 2'h0;
    else if (!settled)
      settle <= 2'(settle + 2'h1);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_select <= `DIV_SEL_RESET;
    else if (wr_div)
      div_select <= next_div_select;
  end

  // Fine value loads from factory trim once synchronisers settle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      loaded <= 1'b0;
      trim_ctrl <= '{1'b0, 1'b0, 1'b0, 1'b0, `FINE_DEFAULT};
    end
    else if (wr_trim)
    begin
      loaded <= 1'b1;
      trim_ctrl.fine_trim_value <= masked_wdata[`F_FINE];
      trim_ctrl.autotrim_ref_select <= masked_wdata[`B_REFSEL];
      trim_ctrl.trim_mode_select <= masked_wdata[`B_MODE_SEL];
      trim_ctrl.autotrim_enable <= masked_wdata[`B_AUTOTRIM_EN];
      trim_ctrl.trim_function_enable <= masked_wdata[`B_TRIM_EN];
    end
    else if (settled && !loaded)
    begin
      loaded <= 1'b1;
      trim_ctrl.fine_trim_value <= fine_sync2;
    end
    else if (auto_trim_active)
      trim_ctrl.fine_trim_value <= atc_value;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fine_trim_to_osc <= 8'h00;
    else
      fine_trim_to_osc <= next_fine;
  end

  // Zero wait: ready answers every setup phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready <= 1'b0;
    else
      pready <= setup;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pslverr <= 1'b0;
    else
      pslverr <= setup && !hit;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else
      prdata <= rd_setup ? next_prdata : 32'h0000_0000;
  end

  // Single free counter on the bus clock feeds every divider
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      free_count <= 5'h00;
    else
      free_count <= 5'(free_count + 5'h01);
  end

  assign shifts[0] = {1'b0, div_select[`F_TMR3]};
  assign shifts[1] = {1'b0, div_select[`F_TMR2]};
  assign shifts[2] = {1'b0, div_select[`F_TMR1]};
  assign shifts[3] = {1'b0, div_select[`F_TMR0]};
  assign shifts[4] = {1'b0, div_select[`F_SCI]};
  assign shifts[5] = 3'({1'b0, div_select[`F_BKP]} + `BKP_BASE_SHIFT);
  assign shifts[6] = {1'b0, div_select[`F_WDT]};
  assign shifts[7] = {1'b0, div_select[`F_ADC]};
  assign shifts[8] = {1'b0, div_select[`F_EXTI]};
  assign shifts[9] = {1'b0, div_select[`F_AFIO]};

  clk_enable_divider u_div_timer3 (
    .pclk(pclk),
    .presetn(presetn),
    .free_count(free_count),
    .shift(shifts[0]),
    .enable(timer3_clk_en)
  );

  clk_enable_divider u_div_timer2 (
    .pclk(pclk),
    .presetn(presetn),
    .free_count(free_count),
    .shift(shifts[1]),
    .enable(timer2_clk_en)
  );

  clk_enable_divider u_div_timer1 (
    .pclk(pclk),
    .presetn(presetn),
    .free_count(free_count),
    .shift(shifts[2]),
    .enable(timer1_clk_en)
  );

  clk_enable_divider u_div_timer0 (
    .pclk(pclk),
    .presetn(presetn),
    .free_count(free_count),
    .shift(shifts[3]),
    .enable(timer0_clk_en)
  );

  clk_enable_divider u_div_smartcard (
    .pclk(pclk),
    .presetn(presetn),
    .free_count(free_count),
    .shift(shifts[4]),
    .enable(smartcard_clk_en)
  );

  clk_enable_divider u_div_backup (
    .pclk(pclk),
    .presetn(presetn),
    .free_count(free_count),
    .shift(shifts[5]),
    .enable(backup_access_clk_en)
  );

  clk_enable_divider u_div_watchdog (
    .pclk(pclk),
    .presetn(presetn),
    .free_count(free_count),
    .shift(shifts[6]),
    .enable(watchdog_access_clk_en)
  );

  clk_enable_divider u_div_converter (
    .pclk(pclk),
    .presetn(presetn),
    .free_count(free_count),
    .shift(shifts[7]),
    .enable(converter_clk_en)
  );

  clk_enable_divider u_div_ext_interrupt (
    .pclk(pclk),
    .presetn(presetn),
    .free_count(free_count),
    .shift(shifts[8]),
    .enable(ext_interrupt_clk_en)
  );

  clk_enable_divider u_div_altfunc (
    .pclk(pclk),
    .presetn(presetn),
    .free_count(free_count),
    .shift(shifts[9]),
    .enable(altfunc_clk_en)
  );
endmodule : clk_presc_select

// file: tb/clk_presc_select_asserts.sv
`timescale 1ns/1ps
module clk_presc_select_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic timer3_clk_en,
  input wire logic backup_access_clk_en,
  input wire logic altfunc_clk_en
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic mapped = (paddr == 12'h03c) || (paddr == 12'h040);
  AST_ZERO_WAIT: assert property (psel && !penable |=> pready)
    else $error("ready missing in access phase");
  AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
    else $error("ready outside access phase");
  AST_ERR_DECODE: assert property (pready |-> pslverr == !mapped)
    else $error("error flag does not match decode");
  AST_ERR_DATA: assert property (pslverr |-> prdata == 32'h0)
    else $error("data not zero on error");
  AST_BKP_MIN: assert property (backup_access_clk_en |=> !backup_access_clk_en [*3])
    else $error("backup enable faster than 1/4");
  AST_BKP_MAX: assert property (backup_access_clk_en |-> ##[1:32] backup_access_clk_en)
    else $error("backup enable slower than 1/32");
  AST_TMR3_MAX: assert property (timer3_clk_en |-> ##[1:8] timer3_clk_en)
    else $error("timer3 enable slower than 1/8");
  AST_ALT_MAX: assert property (altfunc_clk_en |-> ##[1:8] altfunc_clk_en)
    else $error("altfunc enable slower than 1/8");
endmodule : clk_presc_select_asserts

bind clk_presc_select clk_presc_select_asserts u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer3_clk_en(timer3_clk_en),
  .backup_access_clk_en(backup_access_clk_en), .altfunc_clk_en(altfunc_clk_en)
);

// file: tb/tb.sv
`timescale 1ns/1ps
module tb;
  import clk_presc_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pslverr, pready;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, r;
  wire [9:0] en;
  logic lock = 1'b0;
  trim_ctrl_t trim_ctrl;
  logic [7:0] fine_out;
  int bad_count = 0, num_checks = 0, p;
  always #25 pclk = ~pclk;
  clk_presc_select u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .coarse_trim_value(5'h15), .factory_fine_trim(8'h3c),
    .freq_locked_flag(lock), .autotrim_fine_value(8'ha5), .timer3_clk_en(en[9]),
    .timer2_clk_en(en[8]), .timer1_clk_en(en[7]), .timer0_clk_en(en[6]),
    .smartcard_clk_en(en[5]), .backup_access_clk_en(en[4]), .watchdog_access_clk_en(en[3]),
    .converter_clk_en(en[2]), .ext_interrupt_clk_en(en[1]), .altfunc_clk_en(en[0]),
    .trim_ctrl(trim_ctrl), .fine_trim_to_osc(fine_out));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task final_report;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : final_report
  initial
  begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    final_report;
  end
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (5) @(posedge pclk);
    apb(0, 12'h03c, 0); chk(r, 32'h0);
    apb(0, 12'h040, 0); chk(r, 32'h153c_0000);
    lock <= 1'b1;
    apb(0, 12'h044, 0); chk({r[31:1], pslverr}, 32'h1);
    $display("reset and decode test done");
    apb(1, 12'h03c, 32'hffff_ffff); apb(0, 12'h03c, 0); chk(r, 32'hff03_f03f);
    for (int c = 0; c < 4; c++)
    begin
      apb(1, 12'h03c, {16{c[1:0]}});
      repeat (40) @(posedge pclk);
      for (int i = 0; i < 10; i++)
      begin
        @(posedge pclk);
        while (en[i] !== 1'b1) @(posedge pclk);
        p = 0;
        do begin @(posedge pclk); p++; end while (en[i] !== 1'b1);
        chk(p, (i == 4 ? 4 : 1) << c);
      end
    end
    $display("divider test done");
    apb(1, 12'h040, 32'hffff_ffff); apb(0, 12'h040, 0); chk(r, 32'h15ff_00b3);
    repeat (3) @(posedge pclk);
    chk({trim_ctrl, fine_out}, {12'hfff, 8'hff});
    apb(1, 12'h040, 32'h0000_0002);
    repeat (5) @(posedge pclk);
    chk({trim_ctrl.trim_mode_select, trim_ctrl.autotrim_enable, fine_out}, {2'b01, 8'ha5});
    chk(trim_ctrl.fine_trim_value, 8'ha5);
    lock <= 1'b0;
    repeat (3) @(posedge pclk);
    apb(0, 12'h040, 0); chk(r, 32'h15a5_0002);
    $display("trim test done");
    final_report;
  end
endmodule : tb
